// file: hw/asr_pkg.sv
/*
 * Package for the asynchronous serial receiver: APB register map,
 * field positions, reset values, oversampling constants, FSM states
 * and the packed structs that carry bus traffic and module state.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
package asr_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_RCSC  = 8'h00;  // receive_status_control
   localparam logic [7:0] ADDR_RDATA = 8'h04;  // receive_data_reg
   localparam logic [7:0] ADDR_BAUD  = 8'h08;  // 16x tick divisor
   localparam logic [7:0] ADDR_ISTAT = 8'h0c;  // sticky event status
   localparam logic [7:0] ADDR_IMASK = 8'h10;  // event mask

   // receive_status_control field positions
   localparam int BIT_SERIAL_PORT_ENABLE   = 7;
   localparam int BIT_NINE   = 6;
   localparam int BIT_SINGLE = 5;
   localparam int BIT_CONTINUOUS_RECEIVE_ENABLE   = 4;
   localparam int BIT_ADDRESS_DETECT_ENABLE  = 3;
   localparam int BIT_FRAMING_ERROR_FLAG   = 2;
   localparam int BIT_OVERRUN_ERROR_FLAG   = 1;
   localparam int BIT_NINTH  = 0;

   // Event status bits
   localparam int IRQ_W    = 3;
   localparam int IRQ_RX   = 0;
   localparam int IRQ_OVR  = 1;
   localparam int IRQ_FRAMING_ERROR_FLAG = 2;

   // Reset values
   localparam logic [7:0]       RCSC_RST  = 8'h00;
   localparam logic [15:0]      BAUD_RST  = 16'h0043;
   localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

   // Oversampling: 16 ticks per bit, start checked mid-bit
   localparam int         OVERSAMPLE  = 16;
   localparam logic [3:0] MID_SAMPLE  = 4'(OVERSAMPLE / 2 - 1);
   localparam logic [3:0] LAST_SAMPLE = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] LAST_BIT_8  = 4'h7;
   localparam logic [3:0] LAST_BIT_9  = 4'h8;

   // Receive buffer depth
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_START = 4'h2,
      ST_DATA  = 4'h4,
      ST_STOP  = 4'h8
   } asr_rx_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } asr_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } asr_apb_rsp_s;

   typedef struct packed {
      logic       framing_error_flag;
      logic       ninth;
      logic [7:0] data;
   } asr_entry_s;

   typedef struct packed {
      logic                  sync1;
      logic                  sync2;
      asr_rx_e               fsm;
      logic [3:0]            os_cnt;
      logic [3:0]            bit_cnt;
      logic [8:0]            shreg;
      logic [15:0]           baud_cnt;
      asr_entry_s [1:0]      fifo;
      logic                  rd_ptr;
      logic [1:0]            count;
      logic                  serial_port_enable;
      logic                  nine;
      logic                  single;
      logic                  continuous_receive_enable;
      logic                  address_detect_enable;
      logic                  overrun_error_flag;
      logic [15:0]           baud_div;
      logic [IRQ_W-1:0]      istat;
      logic [IRQ_W-1:0]      imask;
      logic [31:0]           prdata;
      logic                  pslverr;
      logic                  pop_ok;
      logic [IRQ_W-1:0]      clr_bits;
   } asr_state_s;

endpackage : asr_pkg

// file: hw/asr_receiver.sv
/*
 * Asynchronous serial receiver with 16x oversampling, 8/9-bit
 * characters, address filtering, two-entry receive buffer, framing
 * and overrun detection, APB register slave and one level interrupt.
 * Assumes pclk at 125 MHz and a receive pin from outside this domain.
 */
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// R1: The receive pin is synchronised and feeds the bit recovery logic.
// R2: The line is sampled on ticks running at sixteen times the baud rate.
// R3: The shift register takes one bit per bit period, not per tick.
// R4: A finished 8- or 9-bit character goes straight into the receive buffer.
// R5: The receive buffer is a FIFO of two characters.
// R6: Reception continues while two characters wait, so a third may start.
// R7: Shift register and buffer entries have no address of their own.
// R8: Software gets characters only by reading the receive data register, oldest first.
// R9: The continuous receive enable bit turns reception on and off.
// R10: The framing error flag shows the head character's framing error, read-only, reset zero.
// R11: A character that completes with the buffer full sets the overrun error flag.
// R12: With 9-bit mode and address detect set, only characters with ninth bit one are kept.
// R13: Character length is eight or nine bits as the nine-bit enable selects.
// R14: With the serial port enable clear the receiver is idle and ignores the pin.
// R15: Reading the receive data register pops the head; ninth bit and framing flag follow.
module asr_receiver (
   // Clock and reset
   input  logic                  pclk,
   input  logic                  presetn,
   // APB slave
   input  asr_pkg::asr_apb_req_s apb_req,
   output asr_pkg::asr_apb_rsp_s apb_rsp,
   // Serial line
   input  logic                  receive_data_pin,
   // Interrupt
   output logic                  irq
);

   localparam int IRQ_SET_W = asr_pkg::IRQ_W;

   asr_pkg::asr_state_s   state_r;
   asr_pkg::asr_state_s   state_nxt;
   logic                  tick;
   logic                  active;
   logic                  done;
   logic                  frame_bad;
   logic                  keep_char;
   logic                  push;
   logic                  pop;
   logic                  full;
   logic                  wr_idx;
   logic                  setup;
   logic                  access;
   logic                  mapped;
   logic [3:0]            last_bit;
   asr_pkg::asr_entry_s   head;
   asr_pkg::asr_entry_s   new_char;
   logic [IRQ_SET_W-1:0]  irq_set;
   logic [7:0]            rcsc_val;

   // Bus phases and buffer head
   assign setup  = apb_req.psel & ~apb_req.penable;
   assign access = apb_req.psel & apb_req.penable;
   assign mapped = (apb_req.paddr == asr_pkg::ADDR_RCSC) || (apb_req.paddr == asr_pkg::ADDR_RDATA) ||
                   (apb_req.paddr == asr_pkg::ADDR_BAUD) || (apb_req.paddr == asr_pkg::ADDR_ISTAT) ||
                   (apb_req.paddr == asr_pkg::ADDR_IMASK);
   assign head   = (state_r.count != 2'h0) ? state_r.fifo[state_r.rd_ptr] : '0;

   // Status/control view; flags of the head entry
   assign rcsc_val = {state_r.serial_port_enable, state_r.nine, state_r.single, state_r.continuous_receive_enable, state_r.address_detect_enable,
                      head.framing_error_flag, state_r.overrun_error_flag, head.ninth};  // R10

   // Whole next-state computation
   always_comb begin
      state_nxt = state_r;
      done      = 1'b0;
      frame_bad = 1'b0;
      pop       = 1'b0;
      push      = 1'b0;
      irq_set   = '0;

      // Pin synchroniser, second stage is the only reader
      state_nxt.sync1 = receive_data_pin;  // R1
      state_nxt.sync2 = state_r.sync1;

      // 16x tick divider
      tick               = (state_r.baud_cnt == 16'h0000);  // R2
      state_nxt.baud_cnt = tick ? state_r.baud_div : state_r.baud_cnt - 16'h0001;

      // Overrun freezes reception until the enable is cleared
      active   = state_r.serial_port_enable & state_r.continuous_receive_enable & ~state_r.overrun_error_flag;  // R9 R14
      last_bit = state_r.nine ? asr_pkg::LAST_BIT_9 : asr_pkg::LAST_BIT_8;  // R13

      // Receive sequencer
      case (state_r.fsm)
         asr_pkg::ST_IDLE: begin
            if (active && !state_r.sync2) begin  // R6
               state_nxt.fsm    = asr_pkg::ST_START;
               state_nxt.os_cnt = 4'h0;
            end
         end
         asr_pkg::ST_START: begin
            if (tick) begin
               if (state_r.os_cnt == asr_pkg::MID_SAMPLE) begin
                  // A glitch shorter than half a bit is not a start
                  if (state_r.sync2) begin
                     state_nxt.fsm = asr_pkg::ST_IDLE;
                  end else begin
                     state_nxt.fsm     = asr_pkg::ST_DATA;
                     state_nxt.os_cnt  = 4'h0;
                     state_nxt.bit_cnt = 4'h0;
                  end
               end else begin
                  state_nxt.os_cnt = state_r.os_cnt + 4'h1;  // R2
               end
            end
         end
         asr_pkg::ST_DATA: begin
            if (tick) begin
               state_nxt.os_cnt = state_r.os_cnt + 4'h1;
               if (state_r.os_cnt == asr_pkg::LAST_SAMPLE) begin
                  // One shift per bit period, LSB first
                  state_nxt.shreg   = {state_r.sync2, state_r.shreg[8:1]};  // R3
                  state_nxt.bit_cnt = state_r.bit_cnt + 4'h1;
                  if (state_r.bit_cnt == last_bit) begin
                     state_nxt.fsm = asr_pkg::ST_STOP;  // R13
                  end
               end
            end
         end
         asr_pkg::ST_STOP: begin
            if (tick) begin
               state_nxt.os_cnt = state_r.os_cnt + 4'h1;
               if (state_r.os_cnt == asr_pkg::LAST_SAMPLE) begin
                  done          = 1'b1;  // R4
                  frame_bad     = ~state_r.sync2;
                  state_nxt.fsm = asr_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt.fsm = asr_pkg::ST_IDLE;
         end
      endcase
      if (!active) begin
         state_nxt.fsm = asr_pkg::ST_IDLE;  // R9 R14
      end

      // Assemble the finished character
      new_char.data  = state_r.nine ? state_r.shreg[7:0] : state_r.shreg[8:1];  // R13
      new_char.ninth = state_r.nine & state_r.shreg[8];
      new_char.framing_error_flag  = frame_bad;
      keep_char      = done & ~(state_r.nine & state_r.address_detect_enable & ~new_char.ninth);  // R12

      // APB setup: capture read data and pending side effects
      if (setup) begin
         state_nxt.pslverr  = ~mapped;  // R7
         state_nxt.prdata   = 32'h0000_0000;
         state_nxt.pop_ok   = 1'b0;
         state_nxt.clr_bits = '0;
         if (!apb_req.pwrite) begin
            case (apb_req.paddr)
               asr_pkg::ADDR_RCSC: state_nxt.prdata = {24'h00_0000, rcsc_val};
               asr_pkg::ADDR_RDATA: begin
                  state_nxt.prdata = {24'h00_0000, head.data};  // R8
                  state_nxt.pop_ok = (state_r.count != 2'h0);
               end
               asr_pkg::ADDR_BAUD: state_nxt.prdata = {16'h0000, state_r.baud_div};
               asr_pkg::ADDR_ISTAT: begin
                  // Clear only what was read, so later events survive
                  state_nxt.prdata   = {29'h0000_0000, state_r.istat};
                  state_nxt.clr_bits = state_r.istat;
               end
               asr_pkg::ADDR_IMASK: state_nxt.prdata = {29'h0000_0000, state_r.imask};
               default: state_nxt.prdata = 32'h0000_0000;
            endcase
         end
      end

      // APB access: writes and read side effects
      if (access) begin
         if (apb_req.pwrite && !state_r.pslverr) begin
            case (apb_req.paddr)
               asr_pkg::ADDR_RCSC: begin
                  state_nxt.serial_port_enable   = apb_req.pwdata[asr_pkg::BIT_SERIAL_PORT_ENABLE];
                  state_nxt.nine   = apb_req.pwdata[asr_pkg::BIT_NINE];
                  state_nxt.single = apb_req.pwdata[asr_pkg::BIT_SINGLE];
                  state_nxt.continuous_receive_enable   = apb_req.pwdata[asr_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];  // R9
                  state_nxt.address_detect_enable  = apb_req.pwdata[asr_pkg::BIT_ADDRESS_DETECT_ENABLE];
               end
               asr_pkg::ADDR_BAUD:  state_nxt.baud_div = apb_req.pwdata[15:0];
               asr_pkg::ADDR_IMASK: state_nxt.imask = apb_req.pwdata[IRQ_SET_W-1:0];
               default: state_nxt.baud_div = state_r.baud_div;
            endcase
         end
         pop                = ~apb_req.pwrite & state_r.pop_ok;  // R15
         state_nxt.pop_ok   = 1'b0;
         state_nxt.clr_bits = '0;
      end
      if (!state_nxt.continuous_receive_enable) begin
         state_nxt.overrun_error_flag = 1'b0;  // R11
      end

      // Two-entry buffer; a pop frees the head slot for a same-cycle push
      full   = (state_r.count == asr_pkg::FIFO_DEPTH) & ~pop;
      wr_idx = state_r.rd_ptr ^ state_r.count[0];
      if (keep_char && !full) begin
         push                      = 1'b1;
         state_nxt.fifo[wr_idx]    = new_char;  // R4 R5
         irq_set[asr_pkg::IRQ_RX]  = 1'b1;
         irq_set[asr_pkg::IRQ_FRAMING_ERROR_FLAG] = frame_bad;
      end else if (keep_char) begin
         state_nxt.overrun_error_flag            = 1'b1;  // R11
         irq_set[asr_pkg::IRQ_OVR] = 1'b1;
      end
      state_nxt.count  = 2'(state_r.count + {1'b0, push} - {1'b0, pop});  // R5
      state_nxt.rd_ptr = state_r.rd_ptr ^ pop;  // R15

      // Sticky events: a set in the clearing cycle wins
      state_nxt.istat = (state_r.istat & ~(access ? state_r.clr_bits : '0)) | irq_set;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r          <= '0;
         state_r.sync1    <= 1'b1;
         state_r.sync2    <= 1'b1;
         state_r.fsm      <= asr_pkg::ST_IDLE;
         state_r.baud_div <= asr_pkg::BAUD_RST;
         state_r.imask    <= asr_pkg::IMASK_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Zero-wait APB answer, data from flip-flops
   assign apb_rsp = '{prdata:  state_r.prdata,
                      pready:  1'b1,
                      pslverr: state_r.pslverr};
   assign irq             = |(state_r.istat & state_r.imask);

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   fifo_bound_a: assert property (state_r.count <= asr_pkg::FIFO_DEPTH)  // R5
      else $error("receive buffer holds more than two");

   sync_start_a: assert property ((state_r.fsm == asr_pkg::ST_IDLE) && active && !state_r.sync2 // R1 R6
      |=> state_r.fsm == asr_pkg::ST_START)
      else $error("start bit not detected");

   tick_only_a: assert property (!tick && (state_r.fsm != asr_pkg::ST_IDLE) && active // R2
      |=> $stable(state_r.os_cnt))
      else $error("sample counter moved without tick");

   bit_period_a: assert property ($changed(state_r.bit_cnt) && ($past(state_r.fsm) == asr_pkg::ST_DATA) // R3
      |-> $past(tick) && ($past(state_r.os_cnt) == asr_pkg::LAST_SAMPLE))
      else $error("shift outside bit boundary");

   push_count_a: assert property (push && !pop && !(access && !apb_req.pwrite) // R4
      |=> state_r.count == $past(state_r.count) + 2'h1)
      else $error("completed character not buffered");

   overrun_set_a: assert property (keep_char && full |=> state_r.overrun_error_flag ##1 (state_r.overrun_error_flag || !state_r.continuous_receive_enable)) // R11
      else $error("overrun not flagged");

   addr_drop_a: assert property (done && state_r.nine && state_r.address_detect_enable && !new_char.ninth |-> !push) // R12
      else $error("data character kept in address mode");

   eight_bit_a: assert property (push && !state_r.nine |=> state_r.fifo[$past(wr_idx)].ninth == 1'b0) // R13
      else $error("ninth bit set in 8-bit mode");

   port_off_a: assert property (!state_r.serial_port_enable || !state_r.continuous_receive_enable |=> state_r.fsm == asr_pkg::ST_IDLE) // R9 R14
      else $error("receiver ran while disabled");

   pop_order_a: assert property (pop |=> state_r.rd_ptr != $past(state_r.rd_ptr)) // R8 R15
      else $error("head not advanced by data read");

   framing_error_flag_view_a: assert property (setup && !apb_req.pwrite && (apb_req.paddr == asr_pkg::ADDR_RCSC) // R10
      |=> state_r.prdata[asr_pkg::BIT_FRAMING_ERROR_FLAG] == $past(head.framing_error_flag))
      else $error("framing flag not from buffer head");

   unmapped_a: assert property (setup && !mapped |=> state_r.pslverr) // R7
      else $error("unmapped address accepted");

   // Receive path: idle, start qualification and bit stepping
   idle_hold_a: assert property ((state_r.fsm == asr_pkg::ST_IDLE) && state_r.sync2 // R1
      |=> state_r.fsm == asr_pkg::ST_IDLE)
      else $error("receiver left idle on a high line");

   start_glitch_a: assert property ((state_r.fsm == asr_pkg::ST_START) && tick && state_r.sync2 // R2
      && (state_r.os_cnt == asr_pkg::MID_SAMPLE) |=> state_r.fsm == asr_pkg::ST_IDLE)
      else $error("short low pulse taken as start");

   shift_step_a: assert property ($changed(state_r.shreg) // R3
      |-> $past(tick) && ($past(state_r.os_cnt) == asr_pkg::LAST_SAMPLE)
          && ($past(state_r.fsm) == asr_pkg::ST_DATA))
      else $error("shift register moved between bit boundaries");

   // Buffer entry, event and overrun hold
   rx_event_a: assert property (push // R4
      |=> state_r.istat[asr_pkg::IRQ_RX] && (state_r.count != 2'h0))
      else $error("buffered character raised no event");

   framing_error_flag_store_a: assert property (push |=> state_r.fifo[$past(wr_idx)].framing_error_flag == $past(frame_bad)) // R10
      else $error("framing result not stored with character");

   addr_keep_a: assert property (done && state_r.nine && state_r.address_detect_enable && new_char.ninth && !full |-> push) // R12
      else $error("address character dropped");

   overrun_error_flag_hold_a: assert property (state_r.overrun_error_flag && state_r.continuous_receive_enable |=> state_r.overrun_error_flag || !state_r.continuous_receive_enable) // R11
      else $error("overrun flag lost with receive still enabled");

   // Software side of the buffer and unmapped reads
   pop_nonempty_a: assert property (pop |-> state_r.count != 2'h0) // R15
      else $error("pop from an empty buffer");

   count_pop_a: assert property (pop && !push |=> state_r.count == $past(state_r.count) - 2'h1) // R15
      else $error("data read did not free an entry");

   rdata_head_a: assert property (setup && !apb_req.pwrite && (apb_req.paddr == asr_pkg::ADDR_RDATA) // R8
      |=> state_r.prdata == {24'h00_0000, $past(head.data)})
      else $error("data read not from buffer head");

   ninth_view_a: assert property (setup && !apb_req.pwrite && (apb_req.paddr == asr_pkg::ADDR_RCSC) // R15
      |=> state_r.prdata[asr_pkg::BIT_NINTH] == $past(head.ninth))
      else $error("ninth bit not from buffer head");

   unmapped_zero_a: assert property (setup && !mapped |=> state_r.prdata == 32'h0000_0000) // R7
      else $error("unmapped address returned data");

   // Main scenarios
   full_cov: cover property (state_r.count == asr_pkg::FIFO_DEPTH && state_r.fsm == asr_pkg::ST_DATA);
   ovr_cov: cover property (keep_char && full);
   framing_error_flag_cov: cover property (push && frame_bad);
   nine_cov: cover property (push && state_r.nine && new_char.ninth);
   pop_push_cov: cover property (push && pop);

endmodule : asr_receiver

// file: verif/asr_tx_model.sv
/*
 * Behavioural remote asynchronous transmitter for the receiver bench.
 * Assumes the caller enters send right after a rising pclk edge and
 * that cyc_per_bit matches the receiver's bit time in pclk cycles.
 */
`timescale 1ns/1ps

module asr_tx_model (
   // Clock and bit time in pclk cycles
   input  wire logic        pclk,
   input  wire logic [15:0] cyc_per_bit,
   // Serial line towards the receiver
   output logic             line
);

   // Line idles at mark level, as a terminal would hold it
   initial line = 1'b1;

   // Hold the line for one bit time
   task automatic hold_bit(input logic v);
      line <= v;
      repeat (cyc_per_bit) @(posedge pclk);
   endtask : hold_bit

   // One frame, LSB first; a zero stop bit forces a framing error
   task automatic send(input logic [7:0] d, input logic nine_en, input logic ninth,
                       input logic stop_ok, input int gap);
      int i;
      hold_bit(1'b0);
      for (i = 0; i < 8; i++) begin
         hold_bit(d[i]);
      end
      if (nine_en) begin
         hold_bit(ninth);
      end
      hold_bit(stop_ok);
      // Idle gap; zero gives back-to-back frames
      for (i = 0; i < gap; i++) begin
         hold_bit(1'b1);
      end
      line <= 1'b1;
   endtask : send

endmodule : asr_tx_model

// file: verif/tb_asr_receiver.sv
/*
 * Self-checking bench for asr_receiver: APB master tasks, a remote
 * transmitter model and register-level scenarios with expected values.
 * Assumes divisor 0 gives 16 pclk cycles per bit and pready answers.
 */
`timescale 1ns/1ps

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_asr_receiver;

   localparam int          BIT_CYC = 16;
   localparam logic [31:0] SP = 32'(1) << asr_pkg::BIT_SERIAL_PORT_ENABLE;
   localparam logic [31:0] NB = 32'(1) << asr_pkg::BIT_NINE;
   localparam logic [31:0] CR = 32'(1) << asr_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE;
   localparam logic [31:0] AD = 32'(1) << asr_pkg::BIT_ADDRESS_DETECT_ENABLE;
   localparam logic [31:0] FE = 32'(1) << asr_pkg::BIT_FRAMING_ERROR_FLAG;
   localparam logic [31:0] OE = 32'(1) << asr_pkg::BIT_OVERRUN_ERROR_FLAG;
   localparam logic [31:0] N9 = 32'(1) << asr_pkg::BIT_NINTH;
   localparam logic [31:0] ON = SP | CR;

   logic                  pclk;
   logic                  presetn;
   asr_pkg::asr_apb_req_s req;
   asr_pkg::asr_apb_rsp_s rsp;
   logic                  line;
   logic                  irq;
   logic [15:0]           bit_cyc;
   int                    miscompares;
   int                    n_checks;

   asr_receiver i_dut (
      .pclk             (pclk),
      .presetn          (presetn),
      .apb_req          (req),
      .apb_rsp          (rsp),
      .receive_data_pin (line),
      .irq              (irq)
   );

   asr_tx_model i_tx (
      .pclk        (pclk),
      .cyc_per_bit (bit_cyc),
      .line        (line)
   );

   // 125 MHz clock
   initial pclk = 1'b0;
   always #4 pclk = ~pclk;

   // Counts and verdict, the single exit of the run
   task automatic results();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // One APB transfer; bounded wait on pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [32:0] r);
      int n;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      // A slave that never answers ends the run as a failure
      if (rsp.pready !== 1'b1) begin
         miscompares++;
         results();
      end
      r = {rsp.pslverr, rsp.prdata};
      req <= '0;
      @(posedge pclk);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [32:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   // Read and compare data plus error response
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
      logic [32:0] r;
      xfer(1'b0, a, 32'h0, r);
      `CHK(r, {ee, e})
   endtask : rd_chk

   // Frame from the remote end, then let status settle
   task automatic rx(input logic [7:0] d, input logic nb, input logic n9, input logic ok, input int gap);
      i_tx.send(d, nb, n9, ok, gap);
      repeat (4) @(posedge pclk);
   endtask : rx

   task automatic endt(input string s);
      $display("test %s done", s);
   endtask : endt

   // Main sequence; frames take 10 or 11 bit times at divisor 0
   initial begin
      presetn = 1'b0;
      req = '0;
      bit_cyc = 16'(BIT_CYC);
      miscompares = 0;
      n_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(asr_pkg::ADDR_RCSC, 32'h0);
      rd_chk(asr_pkg::ADDR_BAUD, 32'h43);
      rd_chk(asr_pkg::ADDR_IMASK, 32'h0);
      rd_chk(8'h14, 32'h0, 1'b1);
      `CHK(irq, 1'b0)
      endt("reset");
      wr(asr_pkg::ADDR_BAUD, 32'h0);
      // The reset divisor count must run out before ticks come every cycle
      repeat (int'(asr_pkg::BAUD_RST) + 1) @(posedge pclk);
      wr(asr_pkg::ADDR_IMASK, 32'h7);
      wr(asr_pkg::ADDR_RCSC, ON);
      rx(8'ha5, 1'b0, 1'b0, 1'b1, 1);
      `CHK(irq, 1'b1)
      rd_chk(asr_pkg::ADDR_RDATA, 32'ha5);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h0);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h1);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h0);
      `CHK(irq, 1'b0)
      endt("single");
      // Three back-to-back frames, no reads: third overruns
      rx(8'h11, 1'b0, 1'b0, 1'b1, 0);
      rx(8'h22, 1'b0, 1'b0, 1'b1, 0);
      rx(8'h33, 1'b0, 1'b0, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_RCSC, ON | OE);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h3);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h11);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h22);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h0);
      wr(asr_pkg::ADDR_RCSC, SP);
      rd_chk(asr_pkg::ADDR_RCSC, SP);
      rx(8'h81, 1'b0, 1'b0, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h0);
      wr(asr_pkg::ADDR_RCSC, ON);
      endt("overrun");
      // Bad stop bit then a good frame
      rx(8'h3c, 1'b0, 1'b0, 1'b0, 2);
      rd_chk(asr_pkg::ADDR_RCSC, ON | FE);
      rx(8'h7e, 1'b0, 1'b0, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h5);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h3c);
      rd_chk(asr_pkg::ADDR_RCSC, ON);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h7e);
      endt("framing");
      // Nine-bit frames with and without address filtering
      wr(asr_pkg::ADDR_RCSC, ON | NB | AD);
      rx(8'h44, 1'b1, 1'b0, 1'b1, 1);
      rx(8'h5a, 1'b1, 1'b1, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_RCSC, ON | NB | AD | N9);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h5a);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h0);
      wr(asr_pkg::ADDR_RCSC, ON | NB);
      rx(8'h66, 1'b1, 1'b0, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_RCSC, ON | NB);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h66);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h1);
      endt("ninebit");
      // Port disabled, then masked event
      wr(asr_pkg::ADDR_RCSC, CR);
      rx(8'h81, 1'b0, 1'b0, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h0);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h0);
      wr(asr_pkg::ADDR_IMASK, 32'h0);
      wr(asr_pkg::ADDR_RCSC, ON);
      rx(8'h12, 1'b0, 1'b0, 1'b1, 1);
      `CHK(irq, 1'b0)
      rd_chk(asr_pkg::ADDR_ISTAT, 32'h1);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h12);
      endt("disable_mask");
      // Divisor one: two pclk per tick, 32 per bit
      wr(asr_pkg::ADDR_BAUD, 32'h1);
      bit_cyc <= 16'(2 * BIT_CYC);
      rd_chk(asr_pkg::ADDR_BAUD, 32'h1);
      rx(8'h96, 1'b0, 1'b0, 1'b1, 1);
      rd_chk(asr_pkg::ADDR_RDATA, 32'h96);
      endt("divisor");
      results();
   end

endmodule : tb_asr_receiver
